// file: pkg/timer_pkg.sv
// timer_pkg: register map, bit positions and reset values of the timers
// assumes an 8-bit register space on one clock, with 16-bit word access at low bytes
// Overview of operation
// R1 - mode 00: count low 5 plus high byte
// R2 - mode 00: top 3 low bits ignored
// R3 - mode 00: 13-bit rollover sets overflow flag
// R4 - mode 01: 16-bit count, rollover sets flag
// R5 - mode 10: low byte counts, reloads from high
// R6 - timer 0 split: low byte own timer
// R7 - split high byte: timer 1 run/flag
// R8 - split: timer 1 runs without run/flag
// R9 - timer 1 in mode 11 halts
// R10 - timer 2 is 16-bit reload counter
// R11 - bit 7: timer 2 rollover flag
// R12 - no timer 2 flag in baud use
// R13 - capture one: bit 7 flags pin edge
// R14 - bit 6: external trigger edge flag
// R15 - bit 5: receive baud source select
// R16 - bit 4: transmit baud source select
// R17 - bit 3: enables external trigger pin
// R18 - bit 2: timer 2 run bit
// R19 - bit 1: clock or input pin falls
// R20 - bit 0: reload or capture function
// R21 - software keeps capture off in baud use
// R22 - 16-bit words at low byte address
// R23 - capture one bytes are read-only
// R24 - gate: count only while pin high
// R25 - counter select counts pin falling edges
// R26 - interrupt entry clears timer 0/1 flag
// R27 - run bits start and stop timers
// R28 - pins synchronised, each edge acts once
package timer_pkg;
  // ********************************
  // register offsets
  // ********************************
  localparam logic [7:0] A_T01CTL = 8'h88;
  localparam logic [7:0] A_T01MOD = 8'h89;
  localparam logic [7:0] A_T0LO   = 8'h8a;
  localparam logic [7:0] A_T1LO   = 8'h8b;
  localparam logic [7:0] A_T0HI   = 8'h8c;
  localparam logic [7:0] A_T1HI   = 8'h8d;
  localparam logic [7:0] A_T2CTL  = 8'hc8;
  localparam logic [7:0] A_TIMER2_MODE  = 8'hc9;
  localparam logic [7:0] A_RCLO   = 8'hca;
  localparam logic [7:0] A_RCHI   = 8'hcb;
  localparam logic [7:0] A_C2LO   = 8'hcc;
  localparam logic [7:0] A_C2HI   = 8'hcd;
  localparam logic [7:0] A_CP1LO  = 8'hce;
  localparam logic [7:0] A_CP1HI  = 8'hcf;
  // ********************************
  // bit positions
  // ********************************
  localparam int B_TF1 = 7;     // timer1_overflow_flag
  localparam int B_TR1 = 6;     // timer1_run_bit
  localparam int B_TF0 = 5;
  localparam int B_TR0 = 4;
  localparam int B_GATE0 = 3;   // gate_enable_n, timer 1 at +4
  localparam int B_CNT0  = 2;   // counter_select_n, timer 1 at +4
  localparam int B_FLG7  = 7;   // overflow or capture one flag
  localparam int B_EXTF  = 6;
  localparam int B_RXSEL = 5;
  localparam int B_TXSEL = 4;
  localparam int B_EXTEN = 3;
  localparam int B_RUN2  = 2;
  localparam int B_SRC2  = 1;
  localparam int B_CAPRL = 0;
  localparam int B_CAP1EN = 0;  // in timer2_mode_reg
  // ********************************
  // modes, reset values, counts
  // ********************************
  typedef enum logic [1:0] {MODE13, MODE16, MODE8R, MODESPLIT} tmode_t;
  localparam logic [7:0]  RST8  = 8'h00;
  localparam logic [15:0] RST16 = 16'h0000;
  localparam int TICK_DIV = 12;  // system clocks per internal count tick
endpackage

// file: hw/timer01_t2.sv
// timer01_t2: timers 0 and 1 in four modes and timer 2 reload/capture
// assumes a one-cycle register port and pins from outside the clock domain
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
module timer01_t2 #(
  parameter int PRESCALE = timer_pkg::TICK_DIV  // clocks per internal tick
) (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  // register port
  input  wire logic [7:0]  ADDR_IN,
  input  wire logic [15:0] WDATA_IN,
  input  wire logic        WORD_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  output logic      [15:0] RDATA_OUT,
  // interrupt entry
  input  wire logic        T0_INT_ACK_IN,
  input  wire logic        T1_INT_ACK_IN,
  // pins
  input  wire logic        EXT_INT0_IN,
  input  wire logic        EXT_INT1_IN,
  input  wire logic        COUNT0_IN,
  input  wire logic        COUNT1_IN,
  input  wire logic        T2_INPUT_IN,
  input  wire logic        T2_EXT_IN,
  // flags and baud pulses
  output logic             T0_OVF_OUT,
  output logic             T1_OVF_OUT,
  output logic             T2_FLAG_OUT,
  output logic             T2_EXTF_OUT,
  output logic             RX_BAUD_OUT,
  output logic             TX_BAUD_OUT
);
  import timer_pkg::*;

  if (PRESCALE < 1 || PRESCALE > 256) begin : g_bad
    $error("PRESCALE must be 1 to 256");
  end

  // ********************************
  // pin synchronisers
  // ********************************
  localparam int NP = 6;
  localparam int P_INT0 = 0;
  localparam int P_INT1 = 1;
  localparam int P_CNT0 = 2;
  localparam int P_CNT1 = 3;
  localparam int P_T2   = 4;
  localparam int P_TIMER2_EXTERNAL_PIN = 5;

  logic [NP-1:0] pin_raw;  // raw pin levels
  logic [NP-1:0] lvl_q;    // filtered levels
  logic [NP-1:0] fall;     // one-cycle falling edges

  assign pin_raw = {T2_EXT_IN, T2_INPUT_IN, COUNT1_IN, COUNT0_IN, EXT_INT1_IN, EXT_INT0_IN};

  for (genvar i = 0; i < NP; i++) begin : g_sync
    logic [2:0] sh_q;  // [0] meta stage, read only by [1]
    // a change counts once stages two and three agree
    always_ff @(posedge CLK_IN or posedge RST_IN) begin
      if (RST_IN) begin
        sh_q     <= 3'h0;
        lvl_q[i] <= 1'b0;
      end else begin
        sh_q <= {sh_q[1:0], pin_raw[i]};
        if (sh_q[1] == sh_q[2]) begin
          lvl_q[i] <= sh_q[2];
        end
      end
    end
    // edge acts exactly once: lvl_q follows next cycle, see R28
    assign fall[i] = lvl_q[i] & ~sh_q[1] & ~sh_q[2];
  end

  // ********************************
  // internal tick divider
  // ********************************
  logic [7:0] div_q;  // prescale count
  logic       tick;   // one-cycle count enable

  assign tick = (div_q == 8'(PRESCALE - 1));

  // free-running divider, no reset-to-phase alignment needed
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      div_q <= 8'h00;
    end else begin
      div_q <= tick ? 8'h00 : div_q + 8'h01;
    end
  end

  // ********************************
  // register port decode
  // ********************************
  logic [7:0]  t01c_q;   // timer 0/1 control
  logic [7:0]  t01m_q;   // timer 0/1 mode
  logic [7:0]  tl0_q;    // timer0_low_byte
  logic [7:0]  th0_q;    // timer0_high_byte
  logic [7:0]  tl1_q;
  logic [7:0]  th1_q;
  logic [7:0]  t2c_q;    // timer2_control_reg
  logic [7:0]  t2m_q;    // timer2_mode_reg
  logic [15:0] rcap_q;   // reload_capture_value
  logic [15:0] cnt2_q;   // timer2_count_word
  logic [15:0] cap1_q;   // capture_one_value
  logic [15:0] rd_q;     // read data
  logic        rxb_q;    // receive baud pulse
  logic        txb_q;    // transmit baud pulse

  // a word access at address a also covers a + 1
  function automatic logic wr(input logic [7:0] a);
    wr = WR_IN & (ADDR_IN == a || (WORD_IN && ADDR_IN == a - 8'h01));
  endfunction

  // byte lane for address a
  function automatic logic [7:0] wb(input logic [7:0] a);
    wb = (ADDR_IN == a) ? WDATA_IN[7:0] : WDATA_IN[15:8];
  endfunction

  // read view of one byte, unmapped reads zero
  function automatic logic [7:0] rbyte(input logic [7:0] a);
    unique case (a)
      A_T01CTL: rbyte = t01c_q;
      A_T01MOD: rbyte = t01m_q;
      A_T0LO:   rbyte = tl0_q;
      A_T1LO:   rbyte = tl1_q;
      A_T0HI:   rbyte = th0_q;
      A_T1HI:   rbyte = th1_q;
      A_T2CTL:  rbyte = t2c_q;
      A_TIMER2_MODE:  rbyte = t2m_q;
      A_RCLO:   rbyte = rcap_q[7:0];
      A_RCHI:   rbyte = rcap_q[15:8];
      A_C2LO:   rbyte = cnt2_q[7:0];
      A_C2HI:   rbyte = cnt2_q[15:8];
      A_CP1LO:  rbyte = cap1_q[7:0];
      A_CP1HI:  rbyte = cap1_q[15:8];
      default:  rbyte = 8'h00;
    endcase
  endfunction

  logic [7:0] w_t01c;  // control after any write
  logic [7:0] w_t2c;
  logic       we_t01c;
  logic       we_t2c;

  assign we_t01c = wr(A_T01CTL);
  assign we_t2c  = wr(A_T2CTL);
  assign w_t01c  = we_t01c ? wb(A_T01CTL) : t01c_q;
  assign w_t2c   = we_t2c ? wb(A_T2CTL) : t2c_q;

  // ********************************
  // timers 0 and 1
  // ********************************
  // next {overflow, high, low} for one count step
  function automatic logic [16:0] step(input tmode_t m, input logic [7:0] lo, input logic [7:0] hi);
    logic [13:0] v13;
    v13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    unique case (m)
      // upper three low bits kept, see R1 R2
      MODE13: step = {v13[13], v13[12:5], lo[7:5], v13[4:0]};
      MODE16: step = {1'b0, hi, lo} + 17'h00001;  // see R4
      MODE8R: step = (lo == 8'hff) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};  // see R5
      MODESPLIT: step = {lo == 8'hff, hi, lo + 8'h01};  // see R6
    endcase
  endfunction

  tmode_t      m0;      // timer 0 mode
  tmode_t      m1;      // timer 1 mode
  logic        split;   // timer 0 split in two
  logic        halt1;   // timer 1 parked in mode 11
  logic        go0;     // timer 0 count enable
  logic        go1;
  logic        goh0;    // split high byte enable
  logic [16:0] s0;
  logic [16:0] s1;
  logic        ovf0;
  logic        ovf1;
  logic        ovfh0;
  logic        tf0_d;
  logic        tf1_d;

  assign m0    = tmode_t'(t01m_q[1:0]);
  assign m1    = tmode_t'(t01m_q[5:4]);
  assign split = (m0 == MODESPLIT);
  assign halt1 = (m1 == MODESPLIT);  // see R9
  // gate and source selection, see R24 R25 R27
  assign go0 = t01c_q[B_TR0] & (~t01m_q[B_GATE0] | lvl_q[P_INT0])
             & (t01m_q[B_CNT0] ? fall[P_CNT0] : tick);
  // run bit ignored while timer 0 is split, see R8
  assign go1 = (split | t01c_q[B_TR1]) & ~halt1 & (~t01m_q[B_GATE0+4] | lvl_q[P_INT1])
             & (t01m_q[B_CNT0+4] ? fall[P_CNT1] : tick);
  assign goh0  = split & t01c_q[B_TR1] & tick;  // see R7
  assign s0    = step(m0, tl0_q, th0_q);
  assign s1    = step(m1, tl1_q, th1_q);
  assign ovf0  = go0 & s0[16];
  assign ovf1  = go1 & s1[16];
  assign ovfh0 = goh0 & (th0_q == 8'hff);
  // hardware set beats the clear in the same cycle, see R3 R26
  assign tf0_d = ovf0 | (w_t01c[B_TF0] & ~(T0_INT_ACK_IN & ~we_t01c));
  // split high byte owns this flag, see R7 R8
  assign tf1_d = (split ? ovfh0 : ovf1) | (w_t01c[B_TF1] & ~(T1_INT_ACK_IN & ~we_t01c));

  // counting bytes, software writes win over counting
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      t01c_q <= RST8;
      t01m_q <= RST8;
      tl0_q  <= RST8;
      th0_q  <= RST8;
      tl1_q  <= RST8;
      th1_q  <= RST8;
    end else begin
      t01c_q <= {tf1_d, w_t01c[6], tf0_d, w_t01c[4:0]};
      t01m_q <= wr(A_T01MOD) ? wb(A_T01MOD) : t01m_q;
      tl0_q  <= wr(A_T0LO) ? wb(A_T0LO) : go0 ? s0[7:0] : tl0_q;
      tl1_q  <= wr(A_T1LO) ? wb(A_T1LO) : go1 ? s1[7:0] : tl1_q;
      th1_q  <= wr(A_T1HI) ? wb(A_T1HI) : go1 ? s1[15:8] : th1_q;
      if (wr(A_T0HI)) begin
        th0_q <= wb(A_T0HI);
      end else if (split) begin  // see R7
        th0_q <= goh0 ? th0_q + 8'h01 : th0_q;
      end else if (go0) begin
        th0_q <= s0[15:8];
      end
    end
  end

  // ********************************
  // timer 2
  // ********************************
  logic baud;    // either serial source picks timer 2
  logic cap1en;  // capture_one_enable in force
  logic go2;     // timer 2 count enable
  logic wrap2;   // 16-bit rollover
  logic exev;    // accepted external trigger edge
  logic cap1ev;  // capture one event
  logic reload;  // load count from reload value
  logic set7;    // bit 7 set event

  assign baud   = t2c_q[B_RXSEL] | t2c_q[B_TXSEL];
  // capture one only with the capture function selected and baud use and pin counting off
  assign cap1en = t2m_q[B_CAP1EN] & ~baud & t2c_q[B_CAPRL] & ~t2c_q[B_SRC2];
  assign go2    = t2c_q[B_RUN2] & (t2c_q[B_SRC2] ? fall[P_T2] : tick);  // see R18 R19
  assign wrap2  = go2 & (cnt2_q == 16'hffff);
  assign exev   = t2c_q[B_EXTEN] & fall[P_TIMER2_EXTERNAL_PIN];  // see R17
  assign cap1ev = cap1en & fall[P_T2];  // see R13
  // baud use forces reload even if capture was left set, see R20 R21
  assign reload = (wrap2 & (~t2c_q[B_CAPRL] | baud)) | (exev & ~t2c_q[B_CAPRL]);
  // overflow flag held off in baud use, see R11 R12
  assign set7   = t2m_q[B_CAP1EN] ? cap1ev : (wrap2 & ~baud);

  // timer 2 registers; word access at the low byte, see R10 R22
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      t2c_q  <= RST8;
      t2m_q  <= RST8;
      rcap_q <= RST16;
      cnt2_q <= RST16;
      cap1_q <= RST16;
    end else begin
      // flags: set wins over a clearing write, see R14
      t2c_q <= {set7 | w_t2c[B_FLG7], exev | w_t2c[B_EXTF], w_t2c[5:0]};
      t2m_q <= wr(A_TIMER2_MODE) ? wb(A_TIMER2_MODE) : t2m_q;
      if (reload) begin  // see R20
        cnt2_q <= rcap_q;
      end else if (go2) begin
        cnt2_q <= cnt2_q + 16'h0001;
      end
      if (wr(A_C2LO)) begin
        cnt2_q[7:0] <= wb(A_C2LO);
      end
      if (wr(A_C2HI)) begin
        cnt2_q[15:8] <= wb(A_C2HI);
      end
      if (exev & t2c_q[B_CAPRL] & ~baud) begin  // see R20
        rcap_q <= cnt2_q;
      end
      if (wr(A_RCLO)) begin
        rcap_q[7:0] <= wb(A_RCLO);
      end
      if (wr(A_RCHI)) begin
        rcap_q[15:8] <= wb(A_RCHI);
      end
      // no write path: read-only, see R23
      if (cap1ev) begin
        cap1_q <= cnt2_q;
      end
    end
  end

  // ********************************
  // baud pulses and read data
  // ********************************
  // registered, so pulses lag the overflow by one cycle
  always_ff @(posedge CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rxb_q <= 1'b0;
      txb_q <= 1'b0;
      rd_q  <= RST16;
    end else begin
      rxb_q <= t2c_q[B_RXSEL] ? wrap2 : ovf1;  // see R15
      txb_q <= t2c_q[B_TXSEL] ? wrap2 : ovf1;  // see R16
      rd_q  <= RD_IN ? {WORD_IN ? rbyte(ADDR_IN + 8'h01) : 8'h00, rbyte(ADDR_IN)} : RST16;
    end
  end

  assign RDATA_OUT   = rd_q;
  assign T0_OVF_OUT  = t01c_q[B_TF0];
  assign T1_OVF_OUT  = t01c_q[B_TF1];
  assign T2_FLAG_OUT = t2c_q[B_FLG7];
  assign T2_EXTF_OUT = t2c_q[B_EXTF];
  assign RX_BAUD_OUT = rxb_q;
  assign TX_BAUD_OUT = txb_q;

  // ********************************
  // assertions
  // ********************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  logic nw0;  // no timer 0 byte writes
  assign nw0 = ~wr(A_T0LO) & ~wr(A_T0HI) & ~we_t01c;

  property p_hi3;
    (m0 == MODE13) & go0 & nw0 |=> tl0_q[7:5] == $past(tl0_q[7:5]);
  endproperty
  a_hi3: assert property (p_hi3) else $error("mode 0 touched upper low bits"); // see R2
  property p_ovf13;
    (m0 == MODE13) & go0 & nw0 & ({th0_q, tl0_q[4:0]} == 13'h1fff)
      |=> t01c_q[B_TF0] && th0_q == 8'h00 && tl0_q[4:0] == 5'h00;
  endproperty
  a_ovf13: assert property (p_ovf13) else $error("13-bit rollover wrong"); // see R3
  property p_ovf16;
    (m1 == MODE16) & ~split & go1 & ~we_t01c & ~wr(A_T1LO) & ~wr(A_T1HI)
      & ({th1_q, tl1_q} == 16'hffff) |=> t01c_q[B_TF1] && tl1_q == 8'h00;
  endproperty
  a_ovf16: assert property (p_ovf16) else $error("16-bit rollover wrong"); // see R4
  property p_rel8;
    (m0 == MODE8R) & go0 & nw0 & (tl0_q == 8'hff) |=> tl0_q == $past(th0_q);
  endproperty
  a_rel8: assert property (p_rel8) else $error("8-bit reload wrong"); // see R5
  property p_split;
    split & goh0 & ~we_t01c & ~wr(A_T0HI) & (th0_q == 8'hff) |=> t01c_q[B_TF1];
  endproperty
  a_split: assert property (p_split) else $error("split high byte flag missed"); // see R7
  property p_halt1;
    halt1 & ~wr(A_T1LO) & ~wr(A_T1HI) |=> $stable(tl1_q) && $stable(th1_q);
  endproperty
  a_halt1: assert property (p_halt1) else $error("timer 1 counted in mode 3"); // see R9
  property p_ack0;
    T0_INT_ACK_IN & ~ovf0 & ~we_t01c |=> ~t01c_q[B_TF0];
  endproperty
  a_ack0: assert property (p_ack0) else $error("interrupt entry kept flag"); // see R26
  property p_noflag;
    baud & ~t2m_q[B_CAP1EN] & ~t2c_q[B_FLG7] & ~we_t2c |=> ~t2c_q[B_FLG7];
  endproperty
  a_noflag: assert property (p_noflag) else $error("flag set in baud use"); // see R12
  property p_cap1;
    cap1ev |=> cap1_q == $past(cnt2_q) && t2c_q[B_FLG7];
  endproperty
  a_cap1: assert property (p_cap1) else $error("capture one missed"); // see R13
  property p_exoff;
    fall[P_TIMER2_EXTERNAL_PIN] & ~t2c_q[B_EXTEN] & ~t2c_q[B_EXTF] & ~we_t2c |=> ~t2c_q[B_EXTF];
  endproperty
  a_exoff: assert property (p_exoff) else $error("trigger pin not ignored"); // see R17
  property p_stop2;
    ~t2c_q[B_RUN2] & ~exev & ~wr(A_C2LO) & ~wr(A_C2HI) |=> $stable(cnt2_q);
  endproperty
  a_stop2: assert property (p_stop2) else $error("stopped timer 2 moved"); // see R18
  property p_once;
    fall[P_T2] |=> ~fall[P_T2] ##1 ~fall[P_T2];
  endproperty
  a_once: assert property (p_once) else $error("edge acted twice"); // see R28
endmodule // timer01_t2

// file: testbench/pin_model.sv
// pin_model: far-side pins of the timers, pulled up while released
// assumes one caller at a time, driving just after rising edges
`timescale 1ns/1ns
module pin_model (
  // clock
  input  wire logic clk_in,
  // pin levels
  output logic      int0_out,
  output logic      int1_out,
  output logic      cnt0_out,
  output logic      cnt1_out,
  output logic      t2_in_out,
  output logic      t2_ext_out
);
  logic [5:0] lvl_q;  // 0 int0, 1 int1, 2 cnt0, 3 cnt1, 4 t2 input, 5 t2 trigger
  initial lvl_q = 6'h3f;  // idle at the pull-up level
  assign {t2_ext_out, t2_in_out, cnt1_out, cnt0_out, int1_out, int0_out} = lvl_q;
  // one falling edge; each level held past the three-flop synchroniser
  task automatic fall(input int k);
    @(posedge clk_in);
    lvl_q[k] <= 1'b0;
    repeat (4) @(posedge clk_in);
    lvl_q[k] <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask
  // static level, used for the gate input
  task automatic hold(input int k, input logic v);
    @(posedge clk_in);
    lvl_q[k] <= v;
  endtask
endmodule // pin_model

// file: testbench/tb_timer01_modes_and_timer2.sv
// tb_timer01_modes_and_timer2: directed tests of the timer block
// assumes PRESCALE 1, so one count per clock; pins come from pin_model
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("FAIL t=%0t got %h want %h", $time, (a), (e)); end end
module tb_timer01_modes_and_timer2;
  import timer_pkg::*;
  // ********************************
  // signals
  // ********************************
  logic        clk_in = 1'b0;   // 50 MHz
  logic        rst_in = 1'b1;   // held two cycles
  logic [7:0]  addr   = 8'h00;
  logic [15:0] wdata  = 16'h0000;
  logic        word   = 1'b0;
  logic        wr_s   = 1'b0;
  logic        rd_s   = 1'b0;
  logic        ack0   = 1'b0;   // interrupt entry, timer 0
  logic        ack1   = 1'b0;   // interrupt entry, timer 1
  logic [15:0] rdata, d;        // read port and last value read
  logic        p_int0, p_int1, p_cnt0, p_cnt1, p_t2in, p_timer2_external_pin;  // pin levels from the model
  logic        t0_ovf, t1_ovf, t2_flag, t2_extf, rx_baud, tx_baud;
  logic [2:0]  flg;
  int          n_fail      = 0;
  int          check_count = 0;
  int          n_rx = 0;        // baud pulse tallies, never cleared
  int          n_tx = 0;
  assign flg = {t2_flag, t1_ovf, t0_ovf};
  always #10 clk_in = ~clk_in;
  // pulses last one cycle, so tally them on every edge
  always @(posedge clk_in) begin
    if (rx_baud === 1'b1) n_rx <= n_rx + 1;
    if (tx_baud === 1'b1) n_tx <= n_tx + 1;
  end
  timer01_t2 #(.PRESCALE(1)) u_dut (
    .CLK_IN(clk_in), .RST_IN(rst_in), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WORD_IN(word), .WR_IN(wr_s), .RD_IN(rd_s), .RDATA_OUT(rdata),
    .T0_INT_ACK_IN(ack0), .T1_INT_ACK_IN(ack1),
    .EXT_INT0_IN(p_int0), .EXT_INT1_IN(p_int1), .COUNT0_IN(p_cnt0),
    .COUNT1_IN(p_cnt1), .T2_INPUT_IN(p_t2in), .T2_EXT_IN(p_timer2_external_pin),
    .T0_OVF_OUT(t0_ovf), .T1_OVF_OUT(t1_ovf), .T2_FLAG_OUT(t2_flag),
    .T2_EXTF_OUT(t2_extf), .RX_BAUD_OUT(rx_baud), .TX_BAUD_OUT(tx_baud));
  pin_model u_pins (
    .clk_in(clk_in), .int0_out(p_int0), .int1_out(p_int1), .cnt0_out(p_cnt0),
    .cnt1_out(p_cnt1), .t2_in_out(p_t2in), .t2_ext_out(p_timer2_external_pin));
  // ********************************
  // bus and helper tasks
  // ********************************
  // one-cycle write; returns just after the edge that took it
  task automatic wr(input logic [7:0] a, input logic w, input logic [15:0] v);
    @(posedge clk_in);
    addr <= a;
    word <= w;
    wdata <= v;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
    #1;
  endtask
  // one-cycle read; data sampled in the single cycle it stands
  task automatic rd(input logic [7:0] a, input logic w);
    @(posedge clk_in);
    addr <= a;
    word <= w;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask
  // bounded wait for a flag; the caller judges it
  task automatic wflag(input int i, input int n);
    int k;
    k = 0;
    while (flg[i] !== 1'b1 && k < n) begin
      @(posedge clk_in);
      #1;
      k++;
    end
  endtask
  task automatic pulse_ack(input logic [1:0] m);
    @(posedge clk_in);
    {ack1, ack0} <= m;
    @(posedge clk_in);
    {ack1, ack0} <= 2'b00;
    #1;
  endtask
  // ********************************
  // scenarios
  // ********************************
  task automatic t_regs();
    rd(A_T2CTL, 1'b0);
    `CHK(d, 16'h0000)
    rd(A_RCLO, 1'b1);
    `CHK(d, RST16)
    rd(A_C2LO, 1'b1);
    `CHK(d, RST16)
    wr(A_CP1LO, 1'b1, 16'habcd);  // capture bytes must not take writes
    rd(A_CP1LO, 1'b1);
    `CHK(d !== 16'habcd, 1'b1)
    $display("test regs done");
  endtask
  task automatic t_t0();
    wr(A_T01MOD, 1'b0, 16'h0001);  // 16-bit
    wr(A_T0LO, 1'b0, 16'h00fd);
    wr(A_T0HI, 1'b0, 16'h00ff);
    wr(A_T01CTL, 1'b0, 16'h0010);
    wflag(0, 12);
    `CHK(t0_ovf, 1'b1)
    pulse_ack(2'b01);
    `CHK(t0_ovf, 1'b0)
    wr(A_T01CTL, 1'b0, 16'h0000);
    wr(A_T01MOD, 1'b0, 16'h0000);  // 13-bit; 0xffbf would take 65 ticks as 16-bit
    wr(A_T0LO, 1'b0, 16'h00bf);
    wr(A_T0HI, 1'b0, 16'h00ff);
    wr(A_T01CTL, 1'b0, 16'h0010);
    wflag(0, 12);
    `CHK(t0_ovf, 1'b1)
    wr(A_T01CTL, 1'b0, 16'h0000);
    rd(A_T0HI, 1'b0);
    `CHK(d, 16'h0000)
    $display("test timer0 modes done");
  endtask
  task automatic t_mode8();
    int r0;
    int t0;
    wr(A_T01MOD, 1'b0, 16'h0022);  // both timers auto-reload
    wr(A_T1HI, 1'b0, 16'h00f0);
    wr(A_T1LO, 1'b0, 16'h00fe);
    wr(A_T0HI, 1'b0, 16'h00f0);
    wr(A_T0LO, 1'b0, 16'h00fe);
    r0 = n_rx;
    t0 = n_tx;
    wr(A_T01CTL, 1'b0, 16'h0050);
    wflag(1, 12);
    `CHK(t1_ovf, 1'b1)
    `CHK(t0_ovf, 1'b1)
    pulse_ack(2'b10);
    `CHK(t1_ovf, 1'b0)
    repeat (40) @(posedge clk_in);
    wr(A_T01CTL, 1'b0, 16'h0000);
    rd(A_T1HI, 1'b0);
    `CHK(d, 16'h00f0)
    rd(A_T1LO, 1'b0);
    `CHK(d[7:4], 4'hf)
    `CHK(n_rx - r0 >= 3, 1'b1)
    `CHK(n_tx - t0 >= 3, 1'b1)
    $display("test reload mode done");
  endtask
  task automatic t_split();
    wr(A_T01MOD, 1'b0, 16'h0013);  // timer 0 split, timer 1 16-bit
    wr(A_T0LO, 1'b0, 16'h00fe);
    wr(A_T0HI, 1'b0, 16'h00fe);
    wr(A_T1LO, 1'b0, 16'h0000);
    wr(A_T01CTL, 1'b0, 16'h0040);  // timer 1 run bit drives the high byte
    wflag(1, 12);
    `CHK(t1_ovf, 1'b1)
    `CHK(t0_ovf, 1'b0)
    wr(A_T01CTL, 1'b0, 16'h0000);
    rd(A_T0LO, 1'b0);
    `CHK(d, 16'h00fe)
    rd(A_T1LO, 1'b0);
    `CHK(d !== 16'h0000, 1'b1)
    wr(A_T01CTL, 1'b0, 16'h0010);
    wflag(0, 12);
    `CHK(t0_ovf, 1'b1)
    wr(A_T01MOD, 1'b0, 16'h0030);  // timer 1 in mode 11
    wr(A_T1LO, 1'b0, 16'h0000);
    wr(A_T01CTL, 1'b0, 16'h0040);
    repeat (10) @(posedge clk_in);
    rd(A_T1LO, 1'b0);
    `CHK(d, 16'h0000)
    wr(A_T01CTL, 1'b0, 16'h0000);
    wr(A_T01MOD, 1'b0, 16'h0000);
    $display("test split mode done");
  endtask
  task automatic t_t2();
    int r0;
    int t0;
    wr(A_RCLO, 1'b1, 16'h1234);
    wr(A_C2LO, 1'b1, 16'hfffd);
    wr(A_T2CTL, 1'b0, 16'h0004);
    wflag(2, 12);
    repeat (5) @(posedge clk_in);
    `CHK(t2_flag, 1'b1)
    wr(A_T2CTL, 1'b0, 16'h0000);
    `CHK(t2_flag, 1'b0)
    rd(A_C2HI, 1'b0);
    `CHK(d, 16'h0012)
    wr(A_RCLO, 1'b1, 16'hfff0);
    wr(A_C2LO, 1'b1, 16'hfff0);  // start near rollover so pulses come within the wait
    r0 = n_rx;
    t0 = n_tx;
    wr(A_T2CTL, 1'b0, 16'h0024);  // capture select kept 0 in baud use
    repeat (40) @(posedge clk_in);
    `CHK(t2_flag, 1'b0)
    `CHK(n_rx - r0 >= 2, 1'b1)
    `CHK(n_tx - t0, 0)
    t0 = n_tx;
    wr(A_T2CTL, 1'b0, 16'h0014);
    repeat (40) @(posedge clk_in);
    `CHK(n_tx - t0 >= 2, 1'b1)
    `CHK(t2_flag, 1'b0)
    wr(A_T2CTL, 1'b0, 16'h0000);
    $display("test timer2 done");
  endtask
  task automatic t_ext();
    wr(A_RCLO, 1'b1, 16'h4321);
    wr(A_C2LO, 1'b1, 16'h0000);
    u_pins.fall(5);
    `CHK(t2_extf, 1'b0)
    wr(A_T2CTL, 1'b0, 16'h0008);
    u_pins.fall(5);
    `CHK(t2_extf, 1'b1)
    rd(A_C2LO, 1'b1);
    `CHK(d, 16'h4321)
    wr(A_C2LO, 1'b1, 16'h5a5a);
    wr(A_T2CTL, 1'b0, 16'h0009);
    `CHK(t2_extf, 1'b0)
    u_pins.fall(5);
    rd(A_RCLO, 1'b1);
    `CHK(d, 16'h5a5a)
    wr(A_TIMER2_MODE, 1'b0, 16'h0001);
    wr(A_C2LO, 1'b1, 16'h0777);
    wr(A_T2CTL, 1'b0, 16'h0001);
    u_pins.fall(4);
    `CHK(t2_flag, 1'b1)
    rd(A_CP1LO, 1'b1);
    `CHK(d, 16'h0777)
    wr(A_T2CTL, 1'b0, 16'h0000);
    wr(A_TIMER2_MODE, 1'b0, 16'h0000);
    $display("test trigger and capture done");
  endtask
  task automatic t_pins();
    wr(A_C2LO, 1'b1, 16'h0000);
    wr(A_T2CTL, 1'b0, 16'h0006);
    repeat (3) u_pins.fall(4);
    rd(A_C2LO, 1'b1);
    `CHK(d, 16'h0003)
    wr(A_T2CTL, 1'b0, 16'h0000);
    wr(A_T01MOD, 1'b0, 16'h0045);  // both timers count their pins
    wr(A_T0LO, 1'b0, 16'h0000);
    wr(A_T1LO, 1'b0, 16'h0000);
    wr(A_T01CTL, 1'b0, 16'h0050);
    repeat (2) u_pins.fall(2);
    u_pins.fall(3);
    rd(A_T0LO, 1'b0);
    `CHK(d, 16'h0002)
    rd(A_T1LO, 1'b0);
    `CHK(d, 16'h0001)
    wr(A_T01CTL, 1'b0, 16'h0000);
    wr(A_T01MOD, 1'b0, 16'h0099);  // both timers gated, 16-bit timing
    wr(A_T0LO, 1'b0, 16'h0000);
    wr(A_T1HI, 1'b0, 16'h00ff);
    wr(A_T1LO, 1'b0, 16'h00fc);  // four counts from rollover
    u_pins.hold(0, 1'b0);
    u_pins.hold(1, 1'b0);
    repeat (4) @(posedge clk_in);
    wr(A_T01CTL, 1'b0, 16'h0050);
    repeat (10) @(posedge clk_in);
    rd(A_T0LO, 1'b0);
    `CHK(d, 16'h0000)
    rd(A_T1LO, 1'b0);
    `CHK(d, 16'h00fc)
    u_pins.hold(0, 1'b1);
    u_pins.hold(1, 1'b1);
    repeat (10) @(posedge clk_in);
    rd(A_T0LO, 1'b0);
    `CHK(d !== 16'h0000, 1'b1)
    `CHK(t1_ovf, 1'b1)
    wr(A_T01CTL, 1'b0, 16'h0000);
    $display("test pins and gate done");
  endtask
  // ********************************
  // run control
  // ********************************
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_regs();
    t_t0();
    t_mode8();
    t_split();
    t_t2();
    t_ext();
    t_pins();
    give_verdict();
  end
  // the tests need about 450 cycles; allow ten thousand
  initial begin
    #200000;
    n_fail++;
    $display("FAIL t=%0t watchdog expired", $time);
    give_verdict();
  end
endmodule // tb_timer01_modes_and_timer2
